// ===== shared/paxs_pkg.sv
// constants of the x/y scan addressing block of the image sensor
// assumes: one core clock, pins from the camera controller are asynchronous
package paxs_pkg;

    // array size, left to right columns, bottom to top rows
    localparam int COL_COUNT = 1280;
    localparam int ROW_COUNT = 1024;
    localparam int COL_W = 11;
    localparam int ROW_W = 10;
    localparam logic [COL_W-1:0] COL_LAST = 11'h4FF;
    localparam logic [ROW_W-1:0] ROW_LAST = 10'h3FF;

    // serial start address: column field above row field, msb first
    localparam int ADDR_W = COL_W + ROW_W;
    localparam int ADDR_COL_LSB = ROW_W;
    localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
    localparam logic [COL_W-1:0] COL_START_RST = 11'h000;
    localparam logic [ROW_W-1:0] ROW_START_RST = 10'h000;

    // parallel pixel outputs
    localparam int LANE_COUNT = 16;
    localparam int LANE_W = 4;

    // pin sampling vector positions
    localparam int PIN_W = 8;
    localparam int PIN_SYNC_X = 0;
    localparam int PIN_CLOCK_X = 1;
    localparam int PIN_SYNC_Y = 2;
    localparam int PIN_CLOCK_Y = 3;
    localparam int PIN_SPI_CLK = 4;
    localparam int PIN_SPI_DATA = 5;
    localparam int PIN_ADDR_LOAD = 6;
    localparam int PIN_SAMPLE = 7;
    localparam logic [PIN_W-1:0] PIN_RST = 8'h00;

    // bayer colour codes, first pixel read out is red
    localparam logic [1:0] COLOUR_RED = 2'h0;
    localparam logic [1:0] COLOUR_GREEN_R = 2'h1;
    localparam logic [1:0] COLOUR_GREEN_B = 2'h2;
    localparam logic [1:0] COLOUR_BLUE = 2'h3;

    function automatic logic [1:0] paxs_colour(input logic row_odd, input logic col_odd);
        paxs_colour = {row_odd, col_odd};
    endfunction : paxs_colour

endpackage : paxs_pkg

// ===== src/paxs_scan_ptr.sv
// one programmable scan pointer (used for the column and the row register)
// assumes: sync_i and step_i are one-cycle pulses on core_clk_i
`timescale 1ns/1ps
module paxs_scan_ptr
    import paxs_pkg::*;
#(
    parameter int W = 11,
    parameter logic [W-1:0] LAST = '1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sync_i,
    input wire logic step_i,
    input wire logic [W-1:0] start_i,
    output logic [W-1:0] ptr_o,
    output logic eos_o
);

    logic [W-1:0] next_ptr;
    logic [W-1:0] start_clamped;

    assign start_clamped = (start_i > LAST) ? LAST : start_i;

    // sync wins over a step in the same cycle; pointer parks on the last stage
    always_comb begin
        next_ptr = ptr_o;
        if (sync_i) begin
            next_ptr = start_clamped;
        end else if (step_i && ptr_o != LAST) begin
            next_ptr = ptr_o + W'(1);
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_o <= RST_VAL;
        end else begin
            ptr_o <= next_ptr;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            eos_o <= 1'b0;
        end else begin
            eos_o <= (next_ptr == LAST) && (ptr_o != LAST || sync_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    sequence s_reach_last;
        (ptr_o != LAST) ##1 (ptr_o == LAST);
    endsequence

    AST_SYNC_START: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sync_i |=> ptr_o == $past(start_clamped))
        else $error("pointer did not take its start on sync");

    AST_STEP_ONE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (step_i && !sync_i && ptr_o != LAST) |=> ptr_o == $past(ptr_o) + W'(1))
        else $error("pointer did not advance by one on step");

    AST_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!step_i && !sync_i) |=> $stable(ptr_o))
        else $error("pointer moved without sync or step");

    AST_EOS_REACH: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_reach_last |-> eos_o)
        else $error("no end of scan when the last stage was reached");

    AST_EOS_CAUSE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        eos_o |-> ptr_o == LAST)
        else $error("end of scan away from the last stage");

endmodule : paxs_scan_ptr

// ===== src/paxs_scan_top.sv
// x/y scan addressing of the 1280 x 1024 global shutter pixel array
// assumes: all inputs are controller pins, asynchronous to core_clk_i,
// each level held at least two core clock cycles
//
// Behaviour
// - column and row start positions are loaded from the serial address
// - a sync pulse puts that register's pointer on its start address, or on its last stage if the start lies beyond it
// - each clock pulse advances only its own pointer by one position, up to its last stage
// - readout is line by line, column by column inside a line
// - scan runs from bottom-left pixel toward top-right pixel
// - pointers cover 1280 columns and 1024 rows
// - start zero gives full frame, other starts give a window
// - one shutter sample pulse reaches every pixel at once
// - exposure sampling runs independently of scanning
// - pixels leave over 16 parallel lanes
// - bayer mosaic with a red first pixel
// - each register pulses its end of scan at its last stage
`timescale 1ns/1ps
module paxs_scan_top
    import paxs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sync_x_i,
    input wire logic clock_x_i,
    input wire logic sync_y_i,
    input wire logic clock_y_i,
    input wire logic spi_clk_i,
    input wire logic spi_data_i,
    input wire logic addr_load_i,
    input wire logic sample_i,
    output logic [COL_W-1:0] col_ptr_o,
    output logic [ROW_W-1:0] row_ptr_o,
    output logic eos_x_o,
    output logic eos_y_o,
    output logic [LANE_W-1:0] out_lane_o,
    output logic [1:0] colour_o,
    output logic array_sample_o
);

    function automatic logic rise_of(input logic cur, input logic prev);
        rise_of = cur & ~prev;
    endfunction : rise_of

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection

    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic [PIN_W-1:0] pin_prev;
    logic [PIN_W-1:0] pin_raw;
    logic sync_x_rise;
    logic clock_x_rise;
    logic sync_y_rise;
    logic clock_y_rise;
    logic spi_clk_rise;
    logic load_rise;
    logic sample_rise;

    assign pin_raw = {sample_i, addr_load_i, spi_data_i, spi_clk_i,
                      clock_y_i, sync_y_i, clock_x_i, sync_x_i};

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta <= PIN_RST;
            pin_sync <= PIN_RST;
            pin_prev <= PIN_RST;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // syncs are taken as active-high pulses
    assign sync_x_rise = rise_of(pin_sync[PIN_SYNC_X], pin_prev[PIN_SYNC_X]);
    assign sync_y_rise = rise_of(pin_sync[PIN_SYNC_Y], pin_prev[PIN_SYNC_Y]);
    assign clock_x_rise = rise_of(pin_sync[PIN_CLOCK_X], pin_prev[PIN_CLOCK_X]);
    assign clock_y_rise = rise_of(pin_sync[PIN_CLOCK_Y], pin_prev[PIN_CLOCK_Y]);
    assign spi_clk_rise = rise_of(pin_sync[PIN_SPI_CLK], pin_prev[PIN_SPI_CLK]);
    assign load_rise = rise_of(pin_sync[PIN_ADDR_LOAD], pin_prev[PIN_ADDR_LOAD]);
    assign sample_rise = rise_of(pin_sync[PIN_SAMPLE], pin_prev[PIN_SAMPLE]);

    ////////////////////////////////////////////////////////////////////////////
    // serial to parallel start address

    logic [ADDR_W-1:0] addr_shift;
    logic [COL_W-1:0] start_col;
    logic [ROW_W-1:0] start_row;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_shift <= ADDR_RST;
        end else if (spi_clk_rise) begin
            addr_shift <= {addr_shift[ADDR_W-2:0], pin_sync[PIN_SPI_DATA]};
        end
    end

    // load takes the word as it stands before a same-cycle shift
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_col <= COL_START_RST;
            start_row <= ROW_START_RST;
        end else if (load_rise) begin
            start_col <= addr_shift[ADDR_W-1:ADDR_COL_LSB];
            start_row <= addr_shift[ROW_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // column and row pointers

    // each register sees only its own sync and clock
    paxs_scan_ptr #(.W(COL_W), .LAST(COL_LAST), .RST_VAL(COL_START_RST)) u_col_ptr (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .sync_i(sync_x_rise),
        .step_i(clock_x_rise),
        .start_i(start_col),
        .ptr_o(col_ptr_o),
        .eos_o(eos_x_o)
    );

    paxs_scan_ptr #(.W(ROW_W), .LAST(ROW_LAST), .RST_VAL(ROW_START_RST)) u_row_ptr (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .sync_i(sync_y_rise),
        .step_i(clock_y_rise),
        .start_i(start_row),
        .ptr_o(row_ptr_o),
        .eos_o(eos_y_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // output lane and colour of the selected pixel, one cycle behind pointers

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_lane_o <= '0;
            colour_o <= COLOUR_RED;
        end else begin
            out_lane_o <= col_ptr_o[LANE_W-1:0];
            colour_o <= paxs_colour(row_ptr_o[0], col_ptr_o[0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // global shutter sample, never gated by the scan

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            array_sample_o <= 1'b0;
        end else begin
            array_sample_o <= sample_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    AST_LOAD_START: assert property (@(posedge core_clk_i) disable iff (rst_i)
        load_rise |=> (start_col == $past(addr_shift[ADDR_W-1:ADDR_COL_LSB]))
                      && (start_row == $past(addr_shift[ROW_W-1:0])))
        else $error("start positions not taken from the serial address");

    AST_SHIFT_IN: assert property (@(posedge core_clk_i) disable iff (rst_i)
        spi_clk_rise |=> addr_shift[0] == $past(pin_sync[PIN_SPI_DATA])
                         && addr_shift[ADDR_W-1:1] == $past(addr_shift[ADDR_W-2:0]))
        else $error("serial address bit not shifted in");

    AST_X_ONLY: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (clock_x_rise && !clock_y_rise && !sync_y_rise) |=> $stable(row_ptr_o))
        else $error("column clock moved the row pointer");

    AST_SAMPLE_ALL: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(pin_sync[PIN_SAMPLE]) |=> array_sample_o ##1 !array_sample_o)
        else $error("shutter sample pulse missing or stretched");

    AST_LANE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ##1 out_lane_o == $past(col_ptr_o[LANE_W-1:0]))
        else $error("output lane does not follow the column");

    AST_RED_FIRST: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (row_ptr_o == ROW_START_RST && col_ptr_o == COL_START_RST) |=> colour_o == COLOUR_RED)
        else $error("first pixel is not red");

    ////////////////////////////////////////////////////////////////////////////
    // pointer moves seen from the pin edges

    sequence s_col_step;
        clock_x_rise && !sync_x_rise && (col_ptr_o != COL_LAST);
    endsequence

    sequence s_row_step;
        clock_y_rise && !sync_y_rise && (row_ptr_o != ROW_LAST);
    endsequence

    AST_Y_ONLY: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (clock_y_rise && !clock_x_rise && !sync_x_rise) |=> $stable(col_ptr_o))
        else $error("row clock moved the column pointer");

    AST_COL_UP: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_col_step |=> col_ptr_o == $past(col_ptr_o) + 11'h001)
        else $error("column pointer did not move one step right");

    AST_ROW_UP: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_row_step |=> row_ptr_o == $past(row_ptr_o) + 10'h001)
        else $error("row pointer did not move one step up");

    AST_COL_SYNC: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sync_x_rise |=> col_ptr_o == (($past(start_col) > COL_LAST) ? COL_LAST
                : $past(start_col)))
        else $error("column sync did not set the column start");

    AST_ROW_SYNC: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sync_y_rise |=> row_ptr_o == $past(start_row))
        else $error("row sync did not set the row start");

    AST_COL_RANGE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        col_ptr_o <= COL_LAST)
        else $error("column pointer outside the array");

    AST_SAMPLE_CAUSE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        array_sample_o |-> $past(sample_rise))
        else $error("shutter sample pulse without a sample edge");

endmodule : paxs_scan_top

// ===== test/paxs_ctrl_model.sv
// camera controller model: scan syncs, scan clocks, serial start load, sample
// assumes: pins change only at falling core clock edges, pulse levels held 3+ cycles, serial clock 2+, serial data 1+
`timescale 1ns/1ps
module paxs_ctrl_model
    import paxs_pkg::*;
(
    input wire logic core_clk_i,
    output logic sync_x_o,
    output logic clock_x_o,
    output logic sync_y_o,
    output logic clock_y_o,
    output logic spi_clk_o,
    output logic spi_data_o,
    output logic addr_load_o,
    output logic sample_o
);
    logic [PIN_W-1:0] pins = PIN_RST;
    assign sync_x_o = pins[PIN_SYNC_X];
    assign clock_x_o = pins[PIN_CLOCK_X];
    assign sync_y_o = pins[PIN_SYNC_Y];
    assign clock_y_o = pins[PIN_CLOCK_Y];
    assign spi_clk_o = pins[PIN_SPI_CLK];
    assign spi_data_o = pins[PIN_SPI_DATA];
    assign addr_load_o = pins[PIN_ADDR_LOAD];
    assign sample_o = pins[PIN_SAMPLE];

    ////////////////////////////////////////////////////////////////////////
    // active-high pulse on one pin, sync, step or sample
    task automatic pulse(input int pin);
        @(negedge core_clk_i);
        pins[pin] = 1'b1;
        repeat (3) @(negedge core_clk_i);
        pins[pin] = 1'b0;
        repeat (4) @(negedge core_clk_i);
    endtask : pulse

    // msb first, data inverted once its hold has run out
    task automatic load_start(input logic [ADDR_W-1:0] word);
        for (int i = ADDR_W - 1; i >= 0; i--) begin
            @(negedge core_clk_i);
            pins[PIN_SPI_DATA] = word[i];
            repeat (2) @(negedge core_clk_i);
            pins[PIN_SPI_CLK] = 1'b1;
            repeat (2) @(negedge core_clk_i);
            pins[PIN_SPI_CLK] = 1'b0;
            @(negedge core_clk_i);
            pins[PIN_SPI_DATA] = ~word[i];
        end
        pulse(PIN_ADDR_LOAD);
    endtask : load_start
endmodule : paxs_ctrl_model

// ===== test/paxs_scan_top_tb_top.sv
// testbench of the scan addressing top with a controller model
// assumes: 10 MHz core clock, pins driven at falling edges
`timescale 1ns/1ps
module paxs_scan_top_tb_top;
    import paxs_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sx, cx, sy, cy, sck, sdat, ld, smp;
    logic [COL_W-1:0] col_ptr_o;
    logic [ROW_W-1:0] row_ptr_o;
    logic eos_x_o, eos_y_o, array_sample_o;
    logic [LANE_W-1:0] out_lane_o;
    logic [1:0] colour_o;
    int mismatches = 0;
    int checks = 0;
    int nx = 0;
    int ny = 0;
    int ns = 0;
    logic [31:0] lfsr = 32'h000158B2;

    always #50 core_clk_i = ~core_clk_i;
    // pulses counted at the falling edge, where they are settled
    always @(negedge core_clk_i) begin
        if (eos_x_o === 1'b1) nx++;
        if (eos_y_o === 1'b1) ny++;
        if (array_sample_o === 1'b1) ns++;
    end

    paxs_ctrl_model i_ctrl (.core_clk_i(core_clk_i), .sync_x_o(sx), .clock_x_o(cx),
        .sync_y_o(sy), .clock_y_o(cy), .spi_clk_o(sck), .spi_data_o(sdat),
        .addr_load_o(ld), .sample_o(smp));
    paxs_scan_top i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .sync_x_i(sx),
        .clock_x_i(cx), .sync_y_i(sy), .clock_y_i(cy), .spi_clk_i(sck), .spi_data_i(sdat),
        .addr_load_i(ld), .sample_i(smp), .col_ptr_o(col_ptr_o), .row_ptr_o(row_ptr_o),
        .eos_x_o(eos_x_o), .eos_y_o(eos_y_o), .out_lane_o(out_lane_o),
        .colour_o(colour_o), .array_sample_o(array_sample_o));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    // bayer mosaic with red at the first pixel of the scan
    function automatic logic [1:0] exp_colour(input logic [ROW_W-1:0] r,
                                              input logic [COL_W-1:0] c);
        case ({r[0], c[0]})
            2'h0: return COLOUR_RED;
            2'h1: return COLOUR_GREEN_R;
            2'h2: return COLOUR_GREEN_B;
            default: return COLOUR_BLUE;
        endcase
    endfunction : exp_colour

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    // pixel position after each move: pointers, lane and bayer colour
    task automatic check_pos(input logic [COL_W-1:0] c, input logic [ROW_W-1:0] r);
        check("col_ptr", 32'(col_ptr_o), 32'(c));
        check("row_ptr", 32'(row_ptr_o), 32'(r));
        check("out_lane", 32'(out_lane_o), 32'(c[3:0]));
        check("colour", 32'(colour_o), 32'(exp_colour(r, c)));
    endtask : check_pos

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [COL_W-1:0] ec;
        logic [COL_W-1:0] sc;
        logic [ROW_W-1:0] er;
        int ex, ey, n;
        repeat (3) @(negedge core_clk_i);
        rst_i = 1'b0;
        check_pos(11'h000, 10'h000);
        for (int k = 0; k < 6; k++) begin
            lfsr = next_rand(lfsr);
            ec = (k == 0) ? 11'h000 : (k == 1) ? COL_LAST - 11'h001 : 11'(lfsr % COL_COUNT);
            er = (k == 0) ? 10'h000 : (k == 1) ? ROW_LAST - 10'h001 : 10'(lfsr % ROW_COUNT);
            // a start beyond the last column parks on the last column
            if (k == 2) ec = 11'h7FF;
            if (k > 0) i_ctrl.load_start({ec, er});
            if (ec > COL_LAST) ec = COL_LAST;
            sc = ec;
            ex = nx + ((ec == COL_LAST) ? 1 : 0);
            ey = ny + ((er == ROW_LAST) ? 1 : 0);
            i_ctrl.pulse(PIN_SYNC_Y);
            i_ctrl.pulse(PIN_SYNC_X);
            check_pos(ec, er);
            n = (k == 1) ? 3 : 1 + int'(lfsr[3:0]);
            for (int s = 0; s < n; s++) begin
                if (ec == COL_LAST - 11'h001) ex++;
                if (ec != COL_LAST) ec++;
                i_ctrl.pulse(PIN_CLOCK_X);
                check_pos(ec, er);
            end
            for (int s = 0; s < 2; s++) begin
                if (er == ROW_LAST - 10'h001) ey++;
                if (er != ROW_LAST) er++;
                i_ctrl.pulse(PIN_CLOCK_Y);
                check_pos(ec, er);
            end
            check("eos_x count", 32'(nx), 32'(ex));
            check("eos_y count", 32'(ny), 32'(ey));
        end
        n = ns;
        fork
            i_ctrl.pulse(PIN_SAMPLE);
            i_ctrl.pulse(PIN_SYNC_X);
        join
        check("sample count", 32'(ns), 32'(n + 1));
        check("col_ptr", 32'(col_ptr_o), 32'(sc));
        complete_run();
    end

    initial begin
        repeat (40000) @(posedge core_clk_i);
        mismatches++;
        complete_run();
    end
endmodule : paxs_scan_top_tb_top
